// ---- spl_pkg.sv ----
// spl_pkg: shared constants and carrier types for the stack pointer logic
// assumes a single system clock and an 8-bit data memory address space
package spl_pkg;

    // special function register address of the pointer
    localparam logic [7:0] SPL_PTR_SFR_ADDR = 8'h81;
    // pointer value after any reset
    localparam logic [7:0] SPL_PTR_RESET = 8'h07;
    // width of pointer and data memory address
    localparam int SPL_ADDR_W = 8;
    // data memory depth in bytes
    localparam int SPL_MEM_DEPTH = 256;
    // step of one push or pop
    localparam logic [7:0] SPL_PTR_STEP = 8'h01;

    // stack request from the instruction sequencer
    typedef struct packed {
        logic push;      // push one byte
        logic pop;       // pop one byte
        logic [7:0] data; // byte to push
    } spl_req_s;

    // special function register access
    typedef struct packed {
        logic wr;        // write strobe
        logic rd;        // read strobe
        logic [7:0] addr; // direct address
        logic [7:0] wdata; // write data
    } spl_sfr_s;

    // indirect data memory access
    typedef struct packed {
        logic we;        // write enable
        logic re;        // read enable
        logic indirect;  // indirect mode, set on every push and pop access
        logic [7:0] addr; // byte address
        logic [7:0] wdata; // write data
    } spl_mem_s;

endpackage : spl_pkg

// ---- spl_ptr_calc.sv ----
// spl_ptr_calc: combinational pointer arithmetic for push and pop
// assumes push and pop are not both requested in one cycle
`timescale 1ns/100ps
module spl_ptr_calc
    import spl_pkg::*;
#(
    parameter int ADDR_W = SPL_ADDR_W
)
(
    input wire logic [ADDR_W-1:0] ptr_i,
    output logic [ADDR_W-1:0] ptr_inc_o,
    output logic [ADDR_W-1:0] ptr_dec_o
);

    // arithmetic wraps modulo the address range
    always_comb
    begin
        ptr_inc_o = ADDR_W'(ptr_i + ADDR_W'(SPL_PTR_STEP));
        ptr_dec_o = ADDR_W'(ptr_i - ADDR_W'(SPL_PTR_STEP));
    end

endmodule : spl_ptr_calc

// ---- spl_stack_ptr.sv ----
// spl_stack_ptr: stack pointer register with push, pop and sfr access
// assumes the sequencer issues one request per cycle and memory reads
// return data combinationally on mem_rdata_i in the cycle of the read
`timescale 1ns/100ps
module spl_stack_ptr
    import spl_pkg::*;
#(
    parameter int ADDR_W = SPL_ADDR_W
)
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire spl_req_s req_i,
    input wire spl_sfr_s sfr_i,
    input wire logic [7:0] mem_rdata_i,
    output spl_mem_s mem_o,
    output logic [7:0] sfr_rdata_o,
    output logic sfr_hit_o,
    output logic [7:0] pop_data_o,
    output logic pop_valid_o,
    output logic [ADDR_W-1:0] ptr_o
);

    // pointer state
    logic [ADDR_W-1:0] ptr_r;
    logic [ADDR_W-1:0] ptr_nxt;
    // registered outputs
    spl_mem_s mem_r;
    spl_mem_s mem_nxt;
    logic [7:0] sfr_rdata_r;
    logic [7:0] sfr_rdata_nxt;
    logic sfr_hit_r;
    logic sfr_hit_nxt;
    logic [7:0] pop_data_r;
    logic [7:0] pop_data_nxt;
    logic pop_valid_r;
    logic pop_valid_nxt;
    // pop pending read of memory
    logic pop_pend_r;
    logic pop_pend_nxt;
    // arithmetic results
    logic [ADDR_W-1:0] ptr_inc;
    logic [ADDR_W-1:0] ptr_dec;
    // requests taken this cycle, after priority
    logic push_take; // push wins over pop and sfr write
    logic pop_take; // pop only without a push
    logic sfr_wr_take; // sfr write only without stack traffic
    logic sfr_rd_take; // read-back of the pointer at its sfr address

    // decode of the pointer's sfr address
    function automatic logic is_ptr_addr(input logic [7:0] a);
        is_ptr_addr = (a == SPL_PTR_SFR_ADDR);
    endfunction : is_ptr_addr

    // modulo pointer arithmetic
    spl_ptr_calc #(
        .ADDR_W(ADDR_W)
    ) u_calc (
        .ptr_i(ptr_r),
        .ptr_inc_o(ptr_inc),
        .ptr_dec_o(ptr_dec)
    );

    // request decode with fixed priority: push, then pop, then sfr write
    // a push and a pop in one cycle act as a push alone
    // the sequencer is expected to issue at most one of them
    always_comb
    begin
        push_take = req_i.push;
        pop_take = req_i.pop && !req_i.push;
        // sfr write yields to any stack traffic in the same cycle
        sfr_wr_take = sfr_i.wr && is_ptr_addr(sfr_i.addr) && !req_i.push && !req_i.pop;
        sfr_rd_take = sfr_i.rd && is_ptr_addr(sfr_i.addr);
    end

    // pointer group: next value of the stack top
    // wrap-around is silent: no overflow or underflow flag exists
    always_comb
    begin
        ptr_nxt = ptr_r; // hold when nothing is taken
        if (push_take)
        begin
            // pointer now marks the byte just written
            ptr_nxt = ptr_inc;
        end
        else if (pop_take)
        begin
            // decrement with wrap, 0x00 goes to 0xFF
            ptr_nxt = ptr_dec;
        end
        else if (sfr_wr_take)
        begin
            // direct write, software may relocate the stack
            ptr_nxt = ADDR_W'(sfr_i.wdata);
        end
    end

    // pointer register, loaded with a fixed value on any reset
    // software may move it before pushing when several banks are in use
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            ptr_r <= ADDR_W'(SPL_PTR_RESET); // first push lands just above bank zero
        end
        else
        begin
            ptr_r <= ptr_nxt;
        end
    end

    // memory request group: one indirect access per stack request
    // the full pointer is the address, so any of 256 bytes is reachable
    // the data bus is zero whenever no write is requested
    always_comb
    begin
        mem_nxt = '0; // strobes last one cycle
        pop_pend_nxt = 1'b0; // no read in flight by default
        if (push_take)
        begin
            // write the byte above the last occupied one
            mem_nxt.we = 1'b1;
            mem_nxt.indirect = 1'b1; // upper half reaches memory, not sfr space
            mem_nxt.addr = 8'(ptr_inc);
            mem_nxt.wdata = req_i.data;
        end
        else if (pop_take)
        begin
            // read the last occupied byte
            mem_nxt.re = 1'b1;
            mem_nxt.indirect = 1'b1;
            mem_nxt.addr = 8'(ptr_r);
            pop_pend_nxt = 1'b1; // byte is captured one cycle later
        end
    end

    // memory request registers, idle after reset
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            mem_r <= '0;
            pop_pend_r <= 1'b0;
        end
        else
        begin
            mem_r <= mem_nxt;
            pop_pend_r <= pop_pend_nxt;
        end
    end

    // sfr read-back group: returns the pointer before any same-cycle update
    // other sfr addresses are ignored without a hit
    always_comb
    begin
        sfr_rdata_nxt = sfr_rdata_r; // read data holds between hits
        sfr_hit_nxt = sfr_rd_take; // one-cycle hit pulse
        if (sfr_rd_take)
        begin
            sfr_rdata_nxt = 8'(ptr_r);
        end
    end

    // sfr read-back registers, cleared by reset
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            sfr_rdata_r <= 8'h00;
            sfr_hit_r <= 1'b0;
        end
        else
        begin
            sfr_rdata_r <= sfr_rdata_nxt;
            sfr_hit_r <= sfr_hit_nxt;
        end
    end

    // popped byte group: memory answers combinationally in the read cycle
    // mem_rdata_i outside that cycle is never captured
    always_comb
    begin
        pop_data_nxt = pop_data_r; // last popped byte holds
        pop_valid_nxt = pop_pend_r; // one-cycle marker of a fresh byte
        if (pop_pend_r)
        begin
            pop_data_nxt = mem_rdata_i;
        end
    end

    // popped byte registers, cleared by reset
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            pop_data_r <= 8'h00;
            pop_valid_r <= 1'b0;
        end
        else
        begin
            pop_data_r <= pop_data_nxt;
            pop_valid_r <= pop_valid_nxt;
        end
    end

    // outputs straight from flip-flops
    assign mem_o = mem_r;
    assign sfr_rdata_o = sfr_rdata_r;
    assign sfr_hit_o = sfr_hit_r;
    assign pop_data_o = pop_data_r;
    assign pop_valid_o = pop_valid_r;
    assign ptr_o = ptr_r;

endmodule : spl_stack_ptr

// ---- spl_stack_ptr_checker.sv ----
// spl_stack_ptr_checker: timing checks on the stack pointer ports
// assumes one clock and sync active-high reset
`timescale 1ns/100ps
module spl_stack_ptr_checker
    import spl_pkg::*;
#(
    parameter int ADDR_W = SPL_ADDR_W
)
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire spl_req_s req_i,
    input wire spl_sfr_s sfr_i,
    input wire logic [7:0] mem_rdata_i,
    input wire spl_mem_s mem_o,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic sfr_hit_o,
    input wire logic [7:0] pop_data_o,
    input wire logic pop_valid_o,
    input wire logic [ADDR_W-1:0] ptr_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // sfr write that reaches the pointer
    wire wr_hit = sfr_i.wr && sfr_i.addr == SPL_PTR_SFR_ADDR && !req_i.push && !req_i.pop;
    push_mem_a: assert property (req_i.push |=> mem_o.we && mem_o.addr == $past(ptr_o) + 8'h01
        && mem_o.wdata == $past(req_i.data) && ptr_o == mem_o.addr) else $error("push access wrong");
    pop_mem_a: assert property (req_i.pop && !req_i.push |=> mem_o.re && mem_o.addr == $past(ptr_o)
        && ptr_o == $past(ptr_o) - 8'h01) else $error("pop access wrong");
    pop_data_a: assert property (mem_o.re |=> pop_valid_o && pop_data_o == $past(mem_rdata_i))
        else $error("pop data wrong");
    reset_ptr_a: assert property (disable iff (1'b0) rst_i |=> ptr_o == SPL_PTR_RESET)
        else $error("reset pointer wrong");
    sfr_write_a: assert property (wr_hit |=> ptr_o == $past(sfr_i.wdata)) else $error("sfr write lost");
    sfr_read_a: assert property (sfr_i.rd && sfr_i.addr == SPL_PTR_SFR_ADDR |=> sfr_hit_o
        && sfr_rdata_o == $past(ptr_o)) else $error("sfr read wrong");
    indirect_mode_a: assert property (mem_o.we || mem_o.re |-> mem_o.indirect)
        else $error("direct stack access");
    ptr_hold_a: assert property (!req_i.push && !req_i.pop && !wr_hit |=> $stable(ptr_o))
        else $error("pointer moved");
    cover property (req_i.push ##1 req_i.pop);
    cover property (wr_hit ##1 req_i.push);
    cover property (pop_valid_o);
endmodule : spl_stack_ptr_checker

bind spl_stack_ptr spl_stack_ptr_checker #(.ADDR_W(ADDR_W)) u_chk (.clk_sys_i, .rst_i, .req_i, .sfr_i,
    .mem_rdata_i, .mem_o, .sfr_rdata_o, .sfr_hit_o, .pop_data_o, .pop_valid_o, .ptr_o);

// ---- test_stack_pointer_logic.sv ----
// test_stack_pointer_logic: push, pop and sfr sequences with a data memory
// assumes the memory answers in the read cycle
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module test_stack_pointer_logic;
    import spl_pkg::*;
    logic clk_sys_i = 0;
    logic rst_i = 1;
    spl_req_s req = '0;
    spl_sfr_s special_function_register = '0;
    spl_mem_s mem_o;
    logic [7:0] ram [256]; // data memory
    logic [7:0] sfr_rdata_o, pop_data_o, ptr_o;
    logic sfr_hit_o, pop_valid_o;
    logic hit_seen; // sfr_hit_o in the answer cycle
    spl_mem_s mem_seen; // mem_o in the answer cycle
    int error_cnt = 0;
    int n_checks = 0;
    always #4 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (mem_o.we) ram[mem_o.addr] <= mem_o.wdata;
    spl_stack_ptr u_dut (.clk_sys_i, .rst_i, .req_i(req), .sfr_i(special_function_register), .mem_rdata_i(ram[mem_o.addr]),
        .mem_o, .sfr_rdata_o, .sfr_hit_o, .pop_data_o, .pop_valid_o, .ptr_o);
    // one request cycle, snapshot of the answer cycle, then settle
    task automatic op(input spl_req_s r, input spl_sfr_s s);
        @(posedge clk_sys_i) #1;
        req = r;
        special_function_register = s;
        @(posedge clk_sys_i) #1;
        hit_seen = sfr_hit_o;
        mem_seen = mem_o;
        req = '0;
        special_function_register = '0;
        @(posedge clk_sys_i) #1;
    endtask : op
    task automatic test_done;
        if (error_cnt == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    initial
    begin
        #20000;
        error_cnt++;
        test_done;
    end
    initial
    begin
        repeat (10) @(posedge clk_sys_i);
        #1 rst_i = 0;
        `CHK(ptr_o, 8'h07)
        `CHK(({sfr_hit_o, pop_valid_o, mem_o.we, mem_o.re}), 4'h0)
        op('0, {2'b01, 8'h81, 8'h00}); `CHK(({hit_seen, sfr_rdata_o}), 9'h107)
        op({2'b10, 8'hA5}, '0); `CHK(ram[8], 8'hA5)
        `CHK(({mem_seen.we, mem_seen.indirect, mem_seen.addr}), 10'h308)
        `CHK(({pop_valid_o, ptr_o}), 9'h008)
        op({2'b01, 8'h00}, '0); `CHK(({pop_valid_o, pop_data_o}), 9'h1A5)
        `CHK(({mem_seen.re, mem_seen.indirect, mem_seen.addr}), 10'h308)
        `CHK(ptr_o, 8'h07)
        op('0, {2'b10, 8'h82, 8'h55}); `CHK(ptr_o, 8'h07)
        op('0, {2'b11, 8'h82, 8'h55}); `CHK(({hit_seen, ptr_o}), 9'h007)
        op('0, {2'b10, 8'h81, 8'hFF}); `CHK(ptr_o, 8'hFF)
        op({2'b10, 8'h3C}, '0); `CHK(ram[0], 8'h3C)
        `CHK(ptr_o, 8'h00)
        op({2'b01, 8'h00}, '0); `CHK(ptr_o, 8'hFF)
        `CHK(pop_data_o, 8'h3C)
        op('0, {2'b10, 8'h81, 8'h7F}); `CHK(ptr_o, 8'h7F)
        op({2'b11, 8'h5A}, '0); `CHK(ram[8'h80], 8'h5A)
        `CHK(ptr_o, 8'h80)
        op({2'b10, 8'h77}, {2'b11, 8'h81, 8'h20}); `CHK(({hit_seen, sfr_rdata_o, ptr_o}), 17'h18081)
        `CHK(ram[8'h81], 8'h77)
        rst_i = 1;
        @(posedge clk_sys_i) #1 rst_i = 0;
        `CHK(({ptr_o, sfr_rdata_o, pop_data_o}), 24'h070000)
        op({2'b10, 8'h11}, '0); `CHK(ram[8], 8'h11)
        test_done;
    end
endmodule : test_stack_pointer_logic
